// ---- common/port_mux_pkg.sv ----
/*
 * Package for the port function and latched address output mux.
 * Assumes an 8-bit host bus with a 16-bit address and one system clock.
 */
package port_mux_pkg;
    localparam int PORT_W = 8;
    localparam int PORTD_W = 3;
    localparam int PIN_COUNT = 27;
    localparam int ADDR_W = 16;
    localparam logic [7:0] OFF_CTRL_A = 8'h02;
    localparam logic [7:0] OFF_CTRL_B = 8'h03;
    localparam logic [7:0] OFF_PAGE = 8'hE0;
    localparam logic [7:0] OFF_TEST_EN = 8'hC7;
    localparam logic [7:0] OFF_DOUT_A = 8'h04;
    localparam logic [7:0] OFF_DOUT_B = 8'h05;
    localparam logic [7:0] OFF_DOUT_C = 8'h12;
    localparam logic [7:0] OFF_DOUT_D = 8'h13;
    localparam logic [7:0] OFF_DIR_A = 8'h06;
    localparam logic [7:0] OFF_DIR_B = 8'h07;
    localparam logic [7:0] OFF_DIR_C = 8'h14;
    localparam logic [7:0] OFF_DIR_D = 8'h15;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam int TMS_BIT = 0;
    localparam int TCK_BIT = 1;
    localparam int STAT_BIT = 3;
    localparam int ERR_BIT = 4;
    localparam int TDI_BIT = 5;
    localparam int TDO_BIT = 6;
    localparam int STROBE_BIT = 0;

    typedef enum logic [1:0] {
        PROF_XA8,
        PROF_PAGE251,
        PROF_MUX8,
        PROF_NONMUX8
    } profile_t;
endpackage

// ---- hw/addr_latch.sv ----
/*
 * Latches the host address on the falling edge of the synchronised
 * address latch strobe and holds it until the next strobe.
 * Assumes the strobe is already synchronised to CLK_SYS_I.
 */
`timescale 1ns/1ps
module addr_latch #(
    parameter int AW = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic strobe_i,
    input wire logic [AW-1:0] addr_i,
    output logic [AW-1:0] addr_o,
    output logic fall_o
);
    logic strobe_d_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strobe_d_r <= 1'b0;
        end else if (ce_i) begin
            strobe_d_r <= strobe_i;
        end
    end

    assign fall_o = strobe_d_r & ~strobe_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_o <= '0;
        end else if (ce_i && fall_o) begin
            addr_o <= addr_i;
        end
    end

    property p_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && !fall_o) |=> $stable(addr_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("latched address changed without a strobe");
endmodule // addr_latch

// ---- hw/port_mux.sv ----
/*
 * Port function mux: 27 pins on ports A-D, latched address outputs,
 * data port mode, test port on port C, page register, register window.
 * Assumes host bus and pins are asynchronous; all are synchronised.
 */
`timescale 1ns/1ps
module port_mux
    import port_mux_pkg::*;
#(
    parameter logic [7:0] WINDOW_BASE = 8'hFF
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire port_mux_pkg::profile_t PROFILE_I,
    input wire logic [port_mux_pkg::ADDR_W-1:0] HOST_ADDR_I,
    input wire logic [7:0] HOST_WDATA_I,
    input wire logic HOST_WR_N_I,
    input wire logic HOST_RD_N_I,
    input wire logic [port_mux_pkg::PIN_COUNT-1:0] LOGIC_SEL_I,
    input wire logic [port_mux_pkg::PIN_COUNT-1:0] LOGIC_OUT_I,
    input wire logic [port_mux_pkg::PIN_COUNT-1:0] LOGIC_OE_I,
    input wire logic ADDR_ON_B_I,
    input wire logic DATA_PORT_EN_I,
    input wire logic [7:0] HOST_DATA_OUT_I,
    input wire logic PROG_STATUS_OUT_I,
    input wire logic PROG_ERROR_OUT_I,
    input wire logic TDO_I,
    input wire logic [port_mux_pkg::PIN_COUNT-1:0] PIN_IN_I,
    output logic [port_mux_pkg::PIN_COUNT-1:0] PIN_OUT_O,
    output logic [port_mux_pkg::PIN_COUNT-1:0] PIN_OE_O,
    output logic [port_mux_pkg::PIN_COUNT-1:0] PIN_SYNC_O,
    output logic [7:0] HOST_DATA_IN_O,
    output logic [7:0] PAGE_O,
    output logic REGISTER_WINDOW_SELECT_O,
    output logic [2:0] HOST_CTRL_O,
    output logic [2:0] TEST_IN_O
);
    import port_mux_pkg::*;

    localparam int NA = PORT_W;
    localparam int NB = 2 * PORT_W;
    localparam int NC = 3 * PORT_W;

    logic [PIN_COUNT-1:0] pin_s1_r;
    logic [PIN_COUNT-1:0] pin_s2_r;
    logic [ADDR_W-1:0] addr_s1_r;
    logic [ADDR_W-1:0] addr_s2_r;
    logic [7:0] wdata_s1_r;
    logic [7:0] wdata_s2_r;
    logic [1:0] ctl_s1_r;
    logic [1:0] ctl_s2_r;
    logic wr_d_r;
    logic wr_pulse;
    logic win_hit;
    logic [7:0] ctrl_a_r;
    logic [7:0] ctrl_b_r;
    logic [7:0] page_r;
    logic test_en_r;
    logic [PIN_COUNT-1:0] dout_r;
    logic [PIN_COUNT-1:0] dir_r;
    logic [ADDR_W-1:0] lat_addr;
    logic lat_fall;
    logic [PIN_COUNT-1:0] out_nxt;
    logic [PIN_COUNT-1:0] oe_nxt;
    logic [PIN_COUNT-1:0] addr_sel;
    logic [PIN_COUNT-1:0] addr_val;
    logic [7:0] lat_hi;
    logic [7:0] lat_lo;

    // Two-stage synchronisers for pins and host bus
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            addr_s1_r <= '0;
            addr_s2_r <= '0;
            wdata_s1_r <= '0;
            wdata_s2_r <= '0;
            ctl_s1_r <= 2'h3;
            ctl_s2_r <= 2'h3;
        end else if (CE_I) begin
            pin_s1_r <= PIN_IN_I;
            pin_s2_r <= pin_s1_r;
            addr_s1_r <= HOST_ADDR_I;
            addr_s2_r <= addr_s1_r;
            wdata_s1_r <= HOST_WDATA_I;
            wdata_s2_r <= wdata_s1_r;
            ctl_s1_r <= {HOST_RD_N_I, HOST_WR_N_I};
            ctl_s2_r <= ctl_s1_r;
        end
    end

    addr_latch #(.AW(ADDR_W)) u_latch (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .strobe_i(pin_s2_r[NC + STROBE_BIT]),
        .addr_i(addr_s2_r),
        .addr_o(lat_addr),
        .fall_o(lat_fall)
    );

    assign win_hit = (addr_s2_r[ADDR_W-1:8] == WINDOW_BASE);
    assign wr_pulse = win_hit & wr_d_r & ~ctl_s2_r[0];

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wr_d_r <= 1'b1;
        end else if (CE_I) begin
            wr_d_r <= ctl_s2_r[0];
        end
    end

    // Register window writes
    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctrl_a_r <= RST_BYTE;
            ctrl_b_r <= RST_BYTE;
            page_r <= RST_BYTE;
            test_en_r <= 1'b0;
            dout_r <= '0;
            dir_r <= '0;
        end else if (CE_I && wr_pulse) begin
            unique case (addr_s2_r[7:0])
                OFF_CTRL_A: ctrl_a_r <= wdata_s2_r;
                OFF_CTRL_B: ctrl_b_r <= wdata_s2_r;
                OFF_PAGE: page_r <= wdata_s2_r;
                OFF_TEST_EN: test_en_r <= wdata_s2_r[0];
                OFF_DOUT_A: dout_r[NA-1:0] <= wdata_s2_r;
                OFF_DOUT_B: dout_r[NB-1:NA] <= wdata_s2_r;
                OFF_DOUT_C: dout_r[NC-1:NB] <= wdata_s2_r;
                OFF_DOUT_D: dout_r[PIN_COUNT-1:NC] <= wdata_s2_r[PORTD_W-1:0];
                OFF_DIR_A: dir_r[NA-1:0] <= wdata_s2_r;
                OFF_DIR_B: dir_r[NB-1:NA] <= wdata_s2_r;
                OFF_DIR_C: dir_r[NC-1:NB] <= wdata_s2_r;
                OFF_DIR_D: dir_r[PIN_COUNT-1:NC] <= wdata_s2_r[PORTD_W-1:0];
                default: ;
            endcase
        end
    end

    // Address nibble map per host profile
    always_comb begin
        addr_sel = '0;
        lat_lo = lat_addr[7:0];
        lat_hi = lat_addr[15:8];
        addr_val = '0;
        unique case (PROFILE_I)
            PROF_XA8: begin
                addr_sel[7:4] = ctrl_a_r[7:4];
                addr_val[7:4] = lat_lo[7:4];
                addr_sel[NA+3:NA] = ctrl_b_r[3:0];
                addr_val[NA+3:NA] = lat_hi[3:0];
            end
            PROF_PAGE251: begin
                addr_sel[NB-1:NA] = ctrl_b_r;
                addr_val[NB-1:NA] = lat_hi;
            end
            PROF_MUX8: begin
                if (ADDR_ON_B_I) begin
                    addr_sel[NB-1:NA] = ctrl_b_r;
                    addr_val[NB-1:NA] = lat_lo;
                end else begin
                    addr_sel[NA-1:0] = ctrl_a_r;
                    addr_val[NA-1:0] = lat_lo;
                end
            end
            PROF_NONMUX8: begin
                addr_sel[NB-1:NA] = ctrl_b_r;
                addr_val[NB-1:NA] = lat_lo;
            end
        endcase
    end

    // Per-pin function select; priority: test port, data port, address, logic, host I/O
    genvar g;
    generate
        for (g = 0; g < PIN_COUNT; g++) begin : g_pin
            always_comb begin
                out_nxt[g] = dout_r[g];
                oe_nxt[g] = dir_r[g];
                if (addr_sel[g]) begin
                    out_nxt[g] = addr_val[g];
                    oe_nxt[g] = 1'b1;
                end else if (LOGIC_SEL_I[g]) begin
                    out_nxt[g] = LOGIC_OUT_I[g];
                    oe_nxt[g] = LOGIC_OE_I[g];
                end
                if (g < NB && DATA_PORT_EN_I && PROFILE_I == PROF_NONMUX8) begin
                    out_nxt[g] = HOST_DATA_OUT_I[g % PORT_W];
                    oe_nxt[g] = ~ctl_s2_r[1] & win_hit;
                end
                if (test_en_r && g >= NB && g < NC) begin
                    if (g - NB == STAT_BIT) begin
                        out_nxt[g] = PROG_STATUS_OUT_I;
                        oe_nxt[g] = 1'b1;
                    end else if (g - NB == ERR_BIT) begin
                        out_nxt[g] = PROG_ERROR_OUT_I;
                        oe_nxt[g] = 1'b1;
                    end else if (g - NB == TDO_BIT) begin
                        out_nxt[g] = TDO_I;
                        oe_nxt[g] = 1'b1;
                    end else if (g - NB == TMS_BIT || g - NB == TCK_BIT
                                 || g - NB == TDI_BIT) begin
                        out_nxt[g] = 1'b0;
                        oe_nxt[g] = 1'b0;
                    end
                end
                if (g == NC + STROBE_BIT && !LOGIC_SEL_I[g]) begin
                    oe_nxt[g] = 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PIN_OUT_O <= '0;
            PIN_OE_O <= '0;
            PIN_SYNC_O <= '0;
            HOST_DATA_IN_O <= '0;
            PAGE_O <= RST_BYTE;
            REGISTER_WINDOW_SELECT_O <= 1'b0;
            HOST_CTRL_O <= 3'h7;
            TEST_IN_O <= '0;
        end else if (CE_I) begin
            PIN_OUT_O <= out_nxt;
            PIN_OE_O <= oe_nxt;
            PIN_SYNC_O <= pin_s2_r;
            HOST_DATA_IN_O <= pin_s2_r[NA-1:0];
            PAGE_O <= page_r;
            REGISTER_WINDOW_SELECT_O <= win_hit;
            HOST_CTRL_O <= {ctl_s2_r, pin_s2_r[NC + STROBE_BIT]};
            TEST_IN_O <= test_en_r ? {pin_s2_r[NB + TDI_BIT], pin_s2_r[NB + TCK_BIT],
                                      pin_s2_r[NB + TMS_BIT]} : 3'h0;
        end
    end

    property p_test_tdo;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (CE_I && test_en_r) |=> (PIN_OE_O[NB + TDO_BIT]
            && PIN_OUT_O[NB + TDO_BIT] == $past(TDO_I));
    endproperty
    a_test_tdo: assert property (p_test_tdo)
        else $error("tdo not driven on port c bit 6");

    property p_xa_a_low;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (PROFILE_I == PROF_XA8) |-> addr_sel[3:0] == 4'h0 && addr_sel[NB-1:NA+4] == 4'h0;
    endproperty
    a_xa_a_low: assert property (p_xa_a_low)
        else $error("xa profile gives address on a forbidden nibble");

    property p_xa_val;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (PROFILE_I == PROF_XA8) |-> addr_val[NA+3:NA] == lat_addr[11:8];
    endproperty
    a_xa_val: assert property (p_xa_val)
        else $error("xa profile port b low nibble not a11-a8");

    property p_page_val;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (PROFILE_I == PROF_PAGE251) |-> addr_val[NB-1:NA] == lat_addr[15:8]
            && addr_sel[NA-1:0] == 8'h00;
    endproperty
    a_page_val: assert property (p_page_val)
        else $error("page profile mapping wrong");

    property p_mux_val;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (PROFILE_I == PROF_MUX8 && !ADDR_ON_B_I) |-> addr_val[NA-1:0] == lat_addr[7:0];
    endproperty
    a_mux_val: assert property (p_mux_val)
        else $error("multiplexed profile port a mapping wrong");

    property p_nonmux_a;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (PROFILE_I == PROF_NONMUX8) |-> addr_sel[NA-1:0] == 8'h00;
    endproperty
    a_nonmux_a: assert property (p_nonmux_a)
        else $error("non-multiplexed profile drives address on port a");

    property p_page_wr;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (CE_I && wr_pulse && addr_s2_r[7:0] == OFF_PAGE) |=> ##1 PAGE_O == $past(wdata_s2_r, 2);
    endproperty
    a_page_wr: assert property (p_page_wr)
        else $error("page register write not seen on output");

    property p_ctrl_a;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (CE_I && wr_pulse && addr_s2_r[7:0] == OFF_CTRL_A) |=> ctrl_a_r == $past(wdata_s2_r);
    endproperty
    a_ctrl_a: assert property (p_ctrl_a)
        else $error("port a control write lost");

    property p_win;
        @(posedge CLK_SYS_I) disable iff (!RST_N_I)
        (CE_I && !win_hit) |=> !REGISTER_WINDOW_SELECT_O;
    endproperty
    a_win: assert property (p_win)
        else $error("window select outside the window");
endmodule // port_mux

// ---- testbench/host_bus_model.sv ----
/*
 * Behavioural 8-bit host: register writes, read strobes and address latch strobes.
 * Assumes a 40 MHz system clock and drives its lines 2 ns after the rising edge.
 */
`timescale 1ns/1ps
module host_bus_model (
    input wire logic clk_i,
    output logic [15:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic strobe_o
);
    initial begin
        addr_o = 16'h0000;
        wdata_o = 8'h00;
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        strobe_o = 1'b1;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    // Address and data settle three cycles before the write strobe and stay while it is low
    task automatic write_reg(input logic [7:0] base, input logic [7:0] off, input logic [7:0] d);
        cyc(1);
        addr_o = {base, off};
        wdata_o = d;
        cyc(3);
        wr_n_o = 1'b0;
        cyc(3);
        wr_n_o = 1'b1;
        cyc(1);
        wdata_o = ~d;
        cyc(3);
    endtask
    // Latch strobe on port D bit 0, address stable three cycles before its fall
    task automatic latch_addr(input logic [15:0] a);
        cyc(1);
        addr_o = a;
        cyc(3);
        strobe_o = 1'b0;
        cyc(3);
        strobe_o = 1'b1;
        cyc(1);
    endtask
    task automatic set_addr(input logic [15:0] a);
        cyc(1);
        addr_o = a;
    endtask
    task automatic set_rd(input logic v);
        cyc(1);
        rd_n_o = v;
    endtask
endmodule // host_bus_model

// ---- testbench/port_mux_tb.sv ----
/*
 * Self-checking bench for the port function mux with a host bus model.
 * Assumes pads loop back: a driven pin reads its own output, else the outside level.
 */
`timescale 1ns/1ps
module port_mux_tb;
    import port_mux_pkg::*;
    localparam logic [7:0] BASE = 8'hA5;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    profile_t profile = PROF_XA8;
    logic [15:0] haddr;
    logic [7:0] hwdata;
    logic wr_n, rd_n, strobe, wsel;
    logic [26:0] lsel = '0, lout = '0, loe = '0, ext = '0;
    logic [26:0] pin_in, pin_out, pin_oe, pin_sync;
    logic addr_on_b = 1'b0, dport_en = 1'b0, stat = 1'b0, err = 1'b0, tdo = 1'b0, ce = 1'b1;
    logic [7:0] hdout = 8'h00, din, page, ma, mb, p;
    logic [2:0] hctrl, tin;
    logic [15:0] a, en;
    logic [19:0] e;
    int n_errors = 0, checked = 0, cycles = 0, seed = 32'h0d23006c;

    assign pin_in = (pin_oe & pin_out) | (~pin_oe & {ext[26:25], strobe, ext[23:0]});

    port_mux #(.WINDOW_BASE(BASE)) port_mux_inst (
        .CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce), .PROFILE_I(profile),
        .HOST_ADDR_I(haddr), .HOST_WDATA_I(hwdata), .HOST_WR_N_I(wr_n), .HOST_RD_N_I(rd_n),
        .LOGIC_SEL_I(lsel), .LOGIC_OUT_I(lout), .LOGIC_OE_I(loe), .ADDR_ON_B_I(addr_on_b),
        .DATA_PORT_EN_I(dport_en), .HOST_DATA_OUT_I(hdout), .PROG_STATUS_OUT_I(stat),
        .PROG_ERROR_OUT_I(err), .TDO_I(tdo), .PIN_IN_I(pin_in), .PIN_OUT_O(pin_out),
        .PIN_OE_O(pin_oe), .PIN_SYNC_O(pin_sync), .HOST_DATA_IN_O(din), .PAGE_O(page),
        .REGISTER_WINDOW_SELECT_O(wsel), .HOST_CTRL_O(hctrl), .TEST_IN_O(tin)
    );
    host_bus_model host_bus_model_inst (
        .clk_i(clk), .addr_o(haddr), .wdata_o(hwdata), .wr_n_o(wr_n), .rd_n_o(rd_n),
        .strobe_o(strobe)
    );

    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Nibble enables {B hi, B lo, A hi, A lo} and the address value for each nibble
    function automatic logic [19:0] exp_nib(profile_t pr, logic onb, logic [15:0] ad);
        case (pr)
            PROF_XA8: return {4'b0110, 4'h0, ad[11:8], ad[7:4], 4'h0};
            PROF_PAGE251: return {4'b1100, ad[15:8], 8'h00};
            PROF_MUX8: return {(onb ? 4'b1100 : 4'b0011), ad[7:0], ad[7:0]};
            default: return {4'b1100, ad[7:0], 8'h00};
        endcase
    endfunction

    initial begin
        cyc(3);
        rst_n = 1'b1;
        cyc(3);
        chk("ctrl_idle", 32'h7, hctrl);
        chk("page_reset", 32'h0, page);
        p = 8'($random(seed));
        host_bus_model_inst.write_reg(BASE, OFF_PAGE, p);
        cyc(2);
        chk("page", p, page);
        host_bus_model_inst.write_reg(BASE ^ 8'h01, OFF_PAGE, ~p);
        cyc(2);
        chk("page_outside", p, page);
        chk("win_sel_out", 32'h0, wsel);
        for (int i = 0; i < 8; i++) begin
            profile = profile_t'(i % 4);
            addr_on_b = (i >= 4);
            ma = (i == 0 || i == 7) ? 8'hFF : 8'($random(seed));
            mb = (i == 0 || i == 7) ? 8'hFF : 8'($random(seed));
            a = 16'($random(seed));
            host_bus_model_inst.write_reg(BASE, OFF_CTRL_A, ma);
            host_bus_model_inst.write_reg(BASE, OFF_CTRL_B, mb);
            host_bus_model_inst.latch_addr(a);
            cyc(6);
            e = exp_nib(profile, addr_on_b, a);
            en = {{4{e[19]}}, {4{e[18]}}, {4{e[17]}}, {4{e[16]}}} & {mb, ma};
            chk("addr_oe", en, pin_oe[15:0]);
            chk("addr_out", e[15:0] & en, pin_out[15:0] & en);
            host_bus_model_inst.set_addr(~a);
            cyc(6);
            chk("addr_hold", e[15:0] & en, pin_out[15:0] & en);
        end
        // A strobe while the clock enable is low must not be latched
        ce = 1'b0;
        host_bus_model_inst.latch_addr(~a);
        cyc(2);
        chk("ce_freeze", e[15:0] & en, pin_out[15:0] & en);
        ce = 1'b1;
        cyc(4);
        chk("ce_resume", e[15:0] & en, pin_out[15:0] & en);
        lsel[23:16] = 8'($random(seed));
        lout[23:16] = 8'($random(seed));
        loe[23:16] = 8'hFF;
        ext[23:16] = 8'($random(seed));
        cyc(5);
        chk("logic_out", lout[23:16] & lsel[23:16], pin_out[23:16] & lsel[23:16]);
        chk("logic_oe", lsel[23:16], pin_oe[23:16] & lsel[23:16]);
        chk("pin_sync", pin_in, pin_sync);
        chk("host_data_in", pin_in[7:0], din);
        lsel = '0;
        {stat, err, tdo} = 3'($random(seed));
        ext[21] = ~ext[21];
        host_bus_model_inst.write_reg(BASE, OFF_TEST_EN, 8'h01);
        cyc(4);
        chk("test_in", {ext[21], ext[17], ext[16]}, tin);
        chk("test_out", {tdo, err, stat}, {pin_out[22], pin_out[20], pin_out[19]});
        chk("test_oe", 32'h7, {pin_oe[22], pin_oe[20], pin_oe[19]});
        host_bus_model_inst.write_reg(BASE, OFF_TEST_EN, 8'h00);
        cyc(4);
        chk("test_off", 32'h0, tin);
        ma = 8'($random(seed));
        mb = 8'($random(seed));
        host_bus_model_inst.write_reg(BASE, OFF_DOUT_C, ma);
        host_bus_model_inst.write_reg(BASE, OFF_DIR_C, mb);
        cyc(2);
        chk("io_out", ma & mb, pin_out[23:16] & mb);
        chk("io_oe", mb, pin_oe[23:16]);
        profile = PROF_NONMUX8;
        dport_en = 1'b1;
        hdout = 8'($random(seed));
        host_bus_model_inst.set_rd(1'b0);
        cyc(4);
        chk("data_port", {hdout, hdout}, pin_out[15:0]);
        chk("data_oe", 32'hFFFF, pin_oe[15:0]);
        chk("win_sel", 32'h1, wsel);
        chk("ctrl_read", 32'h3, hctrl);
        host_bus_model_inst.set_rd(1'b1);
        dport_en = 1'b0;
        cyc(4);
        print_verdict();
    end
endmodule // port_mux_tb
